/* src/classic_timer_counters.sv */
`timescale 1ns/1ps
// Summary of operation
// - Mode 1 timers 0 and 1 chain both bytes into 16 bits, no prescaler.
// - Gate set: timer counts only while run bit set and gate pin high.
// - Gate clear: timer counts whenever its run bit is set.
// - Select bit picks machine cycles when clear, count pin edges when set.
// - Mode 0: high byte plus five low bits as prescaler, 13 bits total.
// - Mode 1: high and low bytes cascade into one 16-bit counter.
// - Mode 2: low byte counts, overflow sets flag, reloads from high byte.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3: low byte is own 8-bit counter with timer 0 controls.
// - Timer 0 mode 3: high byte times cycles, uses timer 1 run and flag.
// - Then timer 1 runs outside mode 3, feeds serial tick, sets no flag.
// - Timer 2 source select bit picks timer or event counter.
// - Capture mode: 16-bit count, overflow sets timer 2 overflow flag.
// - Capture with trigger enable: falling trigger pin copies count to capture.
// - Trigger event sets external flag, an interrupt source like overflow.
// - Auto-reload: rollover sets flag and reloads count from capture pair.
// - Auto-reload with trigger enable: falling trigger forces reload, sets flag.
// - Any receive or transmit clock select puts timer 2 in baud mode.
// - Capture select chooses capture or reload; baud mode forces reload.
// - Timer 2 runs while run bit set; no overflow flag in baud mode.
// - Timer function counts once per machine cycle, twelve clocks.
// - Counter samples pin each machine cycle, counts on high then low.
module classic_timer_counters
    import timer_pkg::*;
#(
    parameter int MC_DIV = OSC_PER_MACHINE_CYCLE
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire reg_req_type bus_req,
    input wire pins_type pins,
    output logic [7:0] rd_data,
    output logic serial_tick_one,
    output logic serial_tick_two
);

    // Divider counter is eight bits wide
    if (MC_DIV < 2 || MC_DIV > 256) begin : g_bad_div
        $error("MC_DIV must lie in 2..256");
    end

    localparam logic [7:0] DIV_LAST = 8'(MC_DIV - 1);

    // ========================================================
    // Counting step shared by timers 0 and 1
    function automatic step_type timer_step(input logic [1:0] mode,
                                            input logic [7:0] tl,
                                            input logic [7:0] th,
                                            input logic inc);
        step_type s;
        logic [5:0] lo5;
        logic [8:0] lo8;
        logic [8:0] hi8;
        s.tl = tl;
        s.th = th;
        s.ovf = 1'b0;
        lo5 = 6'd0;
        lo8 = 9'd0;
        hi8 = 9'd0;
        if (inc) begin
            case (mode)
                MODE_13BIT: begin
                    // Upper three low bits left as they are
                    lo5 = {1'b0, tl[4:0]} + 6'd1;
                    s.tl = {tl[7:5], lo5[4:0]};
                    hi8 = {1'b0, th} + {8'h00, lo5[5]};
                    s.th = hi8[7:0];
                    s.ovf = hi8[8];
                end
                MODE_16BIT: begin
                    lo8 = {1'b0, tl} + 9'd1;
                    hi8 = {1'b0, th} + {8'h00, lo8[8]};
                    s.tl = lo8[7:0];
                    s.th = hi8[7:0];
                    s.ovf = hi8[8];
                end
                MODE_RELOAD8: begin
                    lo8 = {1'b0, tl} + 9'd1;
                    s.tl = lo8[8] ? th : lo8[7:0];
                    s.ovf = lo8[8];
                end
                default: begin
                    // Split mode: low byte alone
                    lo8 = {1'b0, tl} + 9'd1;
                    s.tl = lo8[7:0];
                    s.ovf = lo8[8];
                end
            endcase
        end
        return s;
    endfunction : timer_step

    function automatic logic [7:0] read_mux(input state_type s, input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_TIMER01_MODE: v = s.timer01_mode;
            ADDR_TIMER01_CONTROL: v = s.timer01_control & CONTROL_MASK;
            ADDR_COUNT_LOW_ZERO: v = s.count_low_zero;
            ADDR_COUNT_HIGH_ZERO: v = s.count_high_zero;
            ADDR_COUNT_LOW_ONE: v = s.count_low_one;
            ADDR_COUNT_HIGH_ONE: v = s.count_high_one;
            ADDR_TIMER2_CONTROL: v = s.timer2_control;
            ADDR_TIMER2_COUNT_LOW: v = s.timer2_count_low;
            ADDR_TIMER2_COUNT_HIGH: v = s.timer2_count_high;
            ADDR_CAPTURE_RELOAD_LOW: v = s.capture_reload_low;
            ADDR_CAPTURE_RELOAD_HIGH: v = s.capture_reload_high;
            ADDR_SECOND_CLOCK_SELECT: v = {6'h00, s.second_sel};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    state_type state_q;
    state_type state_d;

    // ========================================================
    // Next-state logic
    logic mc;
    logic fall_zero;
    logic fall_one;
    logic fall_two;
    logic fall_trigger;
    logic [1:0] mode_zero;
    logic [1:0] mode_one;
    logic split_zero;
    logic run_zero;
    logic run_one;
    logic inc_zero;
    logic inc_one;
    logic inc_high_zero;
    logic [8:0] high_zero_sum;
    logic set_tf0;
    logic set_tf1;
    logic [7:0] t2c;
    logic baud;
    logic inc_two;
    logic [16:0] t2_sum;
    logic t2_ovf;
    logic trigger;
    logic set_tf2;
    logic set_timer2_external_flag;
    logic [15:0] t2_next;
    logic wr_ctl;
    logic wr_t2c;
    step_type s0;
    step_type s1;

    always_comb begin
        state_d = state_q;
        mc = (state_q.div == DIV_LAST);
        state_d.div = mc ? 8'h00 : state_q.div + 8'h01;

        // Pins sampled once per machine cycle
        fall_zero = mc & state_q.prev_zero & ~pins.count_pin_zero;
        fall_one = mc & state_q.prev_one & ~pins.count_pin_one;
        fall_two = mc & state_q.prev_two & ~pins.count_pin_two;
        fall_trigger = mc & state_q.prev_trigger & ~pins.timer2_trigger_pin;
        if (mc) begin
            state_d.prev_zero = pins.count_pin_zero;
            state_d.prev_one = pins.count_pin_one;
            state_d.prev_two = pins.count_pin_two;
            state_d.prev_trigger = pins.timer2_trigger_pin;
        end

        // ----------------------------------------------------
        // Timers 0 and 1
        mode_zero = state_q.timer01_mode[MODE_BITS_ZERO +: 2];
        mode_one = state_q.timer01_mode[MODE_BITS_ONE +: 2];
        split_zero = (mode_zero == MODE_SPLIT);
        run_zero = state_q.timer01_control[CTL_RUN_ZERO]
            & (~state_q.timer01_mode[MODE_GATE_ZERO] | pins.gate_pin_zero);
        run_one = state_q.timer01_control[CTL_RUN_ONE]
            & (~state_q.timer01_mode[MODE_GATE_ONE] | pins.gate_pin_one)
            & (mode_one != MODE_SPLIT);
        inc_zero = run_zero
            & (state_q.timer01_mode[MODE_SELECT_ZERO] ? fall_zero : mc);
        inc_one = run_one
            & (state_q.timer01_mode[MODE_SELECT_ONE] ? fall_one : mc);
        s0 = timer_step(mode_zero, state_q.count_low_zero, state_q.count_high_zero, inc_zero);
        s1 = timer_step(mode_one, state_q.count_low_one, state_q.count_high_one, inc_one);

        // Split high byte takes timer 1 run bit and flag
        inc_high_zero = split_zero & state_q.timer01_control[CTL_RUN_ONE] & mc;
        high_zero_sum = {1'b0, state_q.count_high_zero} + {8'h00, inc_high_zero};
        state_d.count_low_zero = s0.tl;
        state_d.count_high_zero = split_zero ? high_zero_sum[7:0] : s0.th;
        state_d.count_low_one = s1.tl;
        state_d.count_high_one = s1.th;
        set_tf0 = s0.ovf;
        set_tf1 = split_zero ? high_zero_sum[8] : s1.ovf;
        state_d.tick_one = s1.ovf;

        // ----------------------------------------------------
        // Timer 2
        t2c = state_q.timer2_control;
        baud = t2c[T2_RECEIVE_SEL] | t2c[T2_TRANSMIT_SEL]
            | state_q.second_sel[SEL2_RECEIVE] | state_q.second_sel[SEL2_TRANSMIT];
        inc_two = t2c[T2_RUN] & (t2c[T2_SOURCE] ? fall_two : mc);
        t2_sum = {1'b0, state_q.timer2_count_high, state_q.timer2_count_low}
            + {16'h0000, inc_two};
        t2_ovf = t2_sum[16];
        trigger = t2c[T2_TRIGGER_EN] & fall_trigger;
        t2_next = t2_sum[15:0];
        if (t2_ovf && (baud || !t2c[T2_CAPTURE_RELOAD])) begin
            t2_next = {state_q.capture_reload_high, state_q.capture_reload_low};
        end
        if (trigger && !baud && !t2c[T2_CAPTURE_RELOAD]) begin
            t2_next = {state_q.capture_reload_high, state_q.capture_reload_low};
        end
        if (trigger && !baud && t2c[T2_CAPTURE_RELOAD]) begin
            state_d.capture_reload_low = state_q.timer2_count_low;
            state_d.capture_reload_high = state_q.timer2_count_high;
        end
        state_d.timer2_count_low = t2_next[7:0];
        state_d.timer2_count_high = t2_next[15:8];
        set_tf2 = t2_ovf & ~baud;
        set_timer2_external_flag = trigger;
        state_d.tick_two = t2_ovf & baud;

        // ----------------------------------------------------
        // Software writes; count bytes written win over counting
        wr_ctl = bus_req.wr && bus_req.addr == ADDR_TIMER01_CONTROL;
        wr_t2c = bus_req.wr && bus_req.addr == ADDR_TIMER2_CONTROL;
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_TIMER01_MODE: state_d.timer01_mode = bus_req.wdata;
                ADDR_COUNT_LOW_ZERO: state_d.count_low_zero = bus_req.wdata;
                ADDR_COUNT_HIGH_ZERO: state_d.count_high_zero = bus_req.wdata;
                ADDR_COUNT_LOW_ONE: state_d.count_low_one = bus_req.wdata;
                ADDR_COUNT_HIGH_ONE: state_d.count_high_one = bus_req.wdata;
                ADDR_TIMER2_COUNT_LOW: state_d.timer2_count_low = bus_req.wdata;
                ADDR_TIMER2_COUNT_HIGH: state_d.timer2_count_high = bus_req.wdata;
                ADDR_CAPTURE_RELOAD_LOW: state_d.capture_reload_low = bus_req.wdata;
                ADDR_CAPTURE_RELOAD_HIGH: state_d.capture_reload_high = bus_req.wdata;
                ADDR_SECOND_CLOCK_SELECT: state_d.second_sel = bus_req.wdata[1:0];
                default: state_d.second_sel = state_d.second_sel;
            endcase
        end

        // Control bytes: written value, then hardware sets win
        state_d.timer01_control = (wr_ctl ? bus_req.wdata : state_q.timer01_control)
            & CONTROL_MASK;
        state_d.timer01_control[CTL_OVERFLOW_ZERO] =
            state_d.timer01_control[CTL_OVERFLOW_ZERO] | set_tf0;
        state_d.timer01_control[CTL_OVERFLOW_ONE] =
            state_d.timer01_control[CTL_OVERFLOW_ONE] | set_tf1;
        state_d.timer2_control = wr_t2c ? bus_req.wdata : state_q.timer2_control;
        state_d.timer2_control[T2_OVERFLOW] =
            state_d.timer2_control[T2_OVERFLOW] | set_tf2;
        state_d.timer2_control[T2_EXTERNAL] =
            state_d.timer2_control[T2_EXTERNAL] | set_timer2_external_flag;

        // Read data stands one cycle only
        state_d.rd_data = bus_req.rd ? read_mux(state_q, bus_req.addr) : 8'h00;
    end

    // ========================================================
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rd_data = state_q.rd_data;
    assign serial_tick_one = state_q.tick_one;
    assign serial_tick_two = state_q.tick_two;

endmodule : classic_timer_counters

/* src/timer_pkg.sv */
package timer_pkg;

    // ========================================================
    // Register indices
    localparam logic [3:0] ADDR_TIMER01_MODE = 4'h0;
    localparam logic [3:0] ADDR_TIMER01_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LOW_ZERO = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HIGH_ZERO = 4'h3;
    localparam logic [3:0] ADDR_COUNT_LOW_ONE = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HIGH_ONE = 4'h5;
    localparam logic [3:0] ADDR_TIMER2_CONTROL = 4'h6;
    localparam logic [3:0] ADDR_TIMER2_COUNT_LOW = 4'h7;
    localparam logic [3:0] ADDR_TIMER2_COUNT_HIGH = 4'h8;
    localparam logic [3:0] ADDR_CAPTURE_RELOAD_LOW = 4'h9;
    localparam logic [3:0] ADDR_CAPTURE_RELOAD_HIGH = 4'ha;
    localparam logic [3:0] ADDR_SECOND_CLOCK_SELECT = 4'hb;

    // ========================================================
    // Field positions
    localparam int MODE_GATE_ONE = 7;
    localparam int MODE_SELECT_ONE = 6;
    localparam int MODE_BITS_ONE = 4;
    localparam int MODE_GATE_ZERO = 3;
    localparam int MODE_SELECT_ZERO = 2;
    localparam int MODE_BITS_ZERO = 0;
    localparam int CTL_OVERFLOW_ONE = 7;
    localparam int CTL_RUN_ONE = 6;
    localparam int CTL_OVERFLOW_ZERO = 5;
    localparam int CTL_RUN_ZERO = 4;
    localparam int T2_OVERFLOW = 7;
    localparam int T2_EXTERNAL = 6;
    localparam int T2_RECEIVE_SEL = 5;
    localparam int T2_TRANSMIT_SEL = 4;
    localparam int T2_TRIGGER_EN = 3;
    localparam int T2_RUN = 2;
    localparam int T2_SOURCE = 1;
    localparam int T2_CAPTURE_RELOAD = 0;
    localparam int SEL2_RECEIVE = 1;
    localparam int SEL2_TRANSMIT = 0;

    // ========================================================
    // Reset values, masks and timing
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'hf0;
    localparam logic [7:0] SEL2_MASK = 8'h03;
    localparam int OSC_PER_MACHINE_CYCLE = 12;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT = 2'b11
    } timer_mode_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic gate_pin_zero;
        logic gate_pin_one;
        logic count_pin_zero;
        logic count_pin_one;
        logic count_pin_two;
        logic timer2_trigger_pin;
    } pins_type;

    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } step_type;

    typedef struct packed {
        logic [7:0] timer01_mode;
        logic [7:0] timer01_control;
        logic [7:0] count_low_zero;
        logic [7:0] count_high_zero;
        logic [7:0] count_low_one;
        logic [7:0] count_high_one;
        logic [7:0] timer2_control;
        logic [7:0] timer2_count_low;
        logic [7:0] timer2_count_high;
        logic [7:0] capture_reload_low;
        logic [7:0] capture_reload_high;
        logic [1:0] second_sel;
        logic [7:0] div;
        logic prev_zero;
        logic prev_one;
        logic prev_two;
        logic prev_trigger;
        logic [7:0] rd_data;
        logic tick_one;
        logic tick_two;
    } state_type;

endpackage : timer_pkg

/* dv/timer_asserts.sv */
`timescale 1ns/1ps
module timer_asserts
    import timer_pkg::*;
#(
    parameter int MC_DIV = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire reg_req_type bus_req,
    input wire pins_type pins,
    input wire logic [7:0] rd_data,
    input wire logic serial_tick_one,
    input wire logic serial_tick_two
);
    // ========================================================
    // Shadow of software-only fields, machine cycle phase
    logic [7:0] mode_q;
    logic [5:2] t2_q;
    logic [1:0] sel_q;
    logic run1_q;
    logic [7:0] div_q;
    logic t1_idle;
    logic t1_gated;
    logic baud;
    assign t1_idle = !run1_q && mode_q[1:0] != 2'b11;
    assign t1_gated = mode_q[7] && !pins.gate_pin_one && mode_q[1:0] != 2'b11;
    assign baud = t2_q[5] || t2_q[4] || sel_q != 2'b00;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            t2_q <= 4'h0;
            sel_q <= 2'h0;
            run1_q <= 1'b0;
            div_q <= 8'h00;
        end else begin
            div_q <= (div_q == 8'(MC_DIV - 1)) ? 8'h00 : div_q + 8'h01;
            if (bus_req.wr && bus_req.addr == ADDR_TIMER01_MODE) mode_q <= bus_req.wdata;
            if (bus_req.wr && bus_req.addr == ADDR_TIMER01_CONTROL) run1_q <= bus_req.wdata[6];
            if (bus_req.wr && bus_req.addr == ADDR_TIMER2_CONTROL) t2_q <= bus_req.wdata[5:2];
            if (bus_req.wr && bus_req.addr == ADDR_SECOND_CLOCK_SELECT) sel_q <= bus_req.wdata[1:0];
        end
    end

    // ========================================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence rd_mode;
        bus_req.rd && bus_req.addr == ADDR_TIMER01_MODE;
    endsequence
    a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    a_mode_read_back: assert property (rd_mode |=> rd_data == $past(mode_q))
        else $error("mode register read back differs");
    a_sel_read_back: assert property (bus_req.rd && bus_req.addr == ADDR_SECOND_CLOCK_SELECT
        |=> rd_data == {6'h00, $past(sel_q)}) else $error("clock select read back differs");
    a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > ADDR_SECOND_CLOCK_SELECT
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    a_tick_one_phase: assert property (serial_tick_one |-> div_q == 8'h00)
        else $error("timer one tick off machine cycle");
    a_tick_two_phase: assert property (serial_tick_two |-> div_q == 8'h00)
        else $error("timer two tick off machine cycle");
    a_mode3_holds: assert property ($past(mode_q[5:4]) == 2'b11 |-> !serial_tick_one)
        else $error("timer one counted in mode three");
    a_stopped_quiet: assert property ($past(t1_idle) |-> !serial_tick_one)
        else $error("timer one counted while stopped");
    a_gate_blocks: assert property ($past(t1_gated) |-> !serial_tick_one)
        else $error("timer one counted with gate low");
    a_baud_only: assert property (serial_tick_two |-> $past(baud))
        else $error("timer two tick outside baud mode");
    a_t2_stopped: assert property ($past(t2_q[2]) == 1'b0 |-> !serial_tick_two)
        else $error("timer two ticked while stopped");
endmodule : timer_asserts

bind classic_timer_counters timer_asserts #(.MC_DIV(MC_DIV)) u_chk (.core_clk(core_clk),
    .rst_n(rst_n), .bus_req(bus_req), .pins(pins), .rd_data(rd_data),
    .serial_tick_one(serial_tick_one), .serial_tick_two(serial_tick_two));

/* dv/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner #(
    parameter int HOLD = 6
) (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [1:0] which,
    input wire logic [3:0] n,
    output logic [3:0] line,
    output logic busy
);
    initial begin
        line = 4'hf;
        busy = 1'b0;
    end
    // ========================================================
    // Falling pulses, each level held several machine cycles
    always @(posedge core_clk) begin
        if (go) begin
            busy <= 1'b1;
            repeat (n) begin
                line[which] <= 1'b0;
                repeat (HOLD) @(posedge core_clk);
                line[which] <= 1'b1;
                repeat (HOLD) @(posedge core_clk);
            end
            busy <= 1'b0;
        end
    end
endmodule : pin_partner

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import timer_pkg::*;
;
    localparam int DIV = 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_type bus_req = '0;
    pins_type pins;
    logic g0 = 1'b1;
    logic g1 = 1'b1;
    logic go = 1'b0;
    logic [1:0] which = 2'd0;
    logic [3:0] n = 4'd0;
    logic [3:0] line;
    logic busy;
    logic tick_one;
    logic tick_two;
    logic [7:0] rd_data;
    logic rd_pend = 1'b0;
    logic [11:0] exp_q[$];
    logic [3:0] rw_a[9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha};
    logic [7:0] v;
    int checked = 0;
    int miscompares = 0;
    int ticks_one = 0;
    int ticks_two = 0;
    int seed = 32'ha4fc;
    assign pins = '{g0, g1, line[0], line[1], line[2], line[3]};
    always #25 core_clk = ~core_clk;

    classic_timer_counters #(.MC_DIV(DIV)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .bus_req(bus_req), .pins(pins), .rd_data(rd_data), .serial_tick_one(tick_one),
        .serial_tick_two(tick_two));
    pin_partner #(.HOLD(3 * DIV)) u_pins (.core_clk(core_clk), .go(go), .which(which),
        .n(n), .line(line), .busy(busy));

    // ========================================================
    // Tasks
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value reg %h expected %h seen %h", a, e, g);
        end
    endtask : chk
    task automatic chk_ticks(input int e1, input int e2);
        checked++;
        if (ticks_one != e1 || ticks_two != e2) begin
            miscompares++;
            $display("wrong value serial ticks expected %0d %0d seen %0d %0d", e1, e2,
                ticks_one, ticks_two);
        end
    endtask : chk_ticks
    task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, w, !w};
        if (!w) exp_q.push_back({a, d});
        @(posedge core_clk);
        bus_req <= '0;
    endtask : op
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        op(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        op(1'b0, a, e);
    endtask : rd
    task automatic pulse(input logic [1:0] w, input logic [3:0] k);
        int i;
        @(posedge core_clk);
        which <= w;
        n <= k;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (i = 0; i < 2000; i++) begin
            @(posedge core_clk);
            if (!busy) break;
        end
        if (i == 2000) begin
            miscompares++;
            wrap_up();
        end
    endtask : pulse

    // ========================================================
    // Read data monitor
    always @(posedge core_clk) begin : mon
        logic [11:0] e;
        if (rd_pend) begin
            e = exp_q.pop_front();
            chk(e[11:8], e[7:0], rd_data);
        end
        rd_pend <= bus_req.rd;
        if (tick_one) begin
            ticks_one++;
        end
        if (tick_two) begin
            ticks_two++;
        end
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), 8'h00);
        end
        foreach (rw_a[k]) begin
            v = 8'($random(seed));
            wr(rw_a[k], v);
            rd(rw_a[k], v);
        end
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h03);
        wr(4'hb, 8'h00);
        wr(4'h6, 8'h3b);
        rd(4'h6, 8'h3b);
        wr(4'h6, 8'h00);
        // Timer 0 counting pin edges in 16-bit, 13-bit and split modes
        wr(4'h0, 8'h05);
        wr(4'h2, 8'hfe);
        wr(4'h3, 8'h12);
        wr(4'h1, 8'h10);
        pulse(2'd0, 4'd3);
        rd(4'h2, 8'h01);
        rd(4'h3, 8'h13);
        wr(4'h0, 8'h04);
        wr(4'h2, 8'hbe);
        wr(4'h3, 8'h05);
        pulse(2'd0, 4'd3);
        rd(4'h2, 8'ha1);
        rd(4'h3, 8'h06);
        wr(4'h0, 8'h07);
        wr(4'h2, 8'hf0);
        pulse(2'd0, 4'd2);
        rd(4'h2, 8'hf2);
        rd(4'h3, 8'h06);
        wr(4'h1, 8'h00);
        // Timer 1 gating, mode 3 hold, 8-bit reload
        wr(4'h0, 8'hd0);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h00);
        g1 <= 1'b0;
        wr(4'h1, 8'h40);
        pulse(2'd1, 4'd2);
        rd(4'h4, 8'h00);
        g1 <= 1'b1;
        pulse(2'd1, 4'd2);
        rd(4'h4, 8'h02);
        wr(4'h0, 8'h50);
        g1 <= 1'b0;
        pulse(2'd1, 4'd1);
        rd(4'h4, 8'h03);
        wr(4'h0, 8'h70);
        pulse(2'd1, 4'd2);
        rd(4'h4, 8'h03);
        wr(4'h0, 8'h60);
        wr(4'h4, 8'hfe);
        wr(4'h5, 8'h80);
        pulse(2'd1, 4'd3);
        rd(4'h4, 8'h81);
        rd(4'h5, 8'h80);
        rd(4'h1, 8'hc0);
        chk_ticks(1, 0);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h00);
        // Timer function: split timer 0, timer 1 held, timer 2 on cycles
        wr(4'h0, 8'h33);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h7, 8'h00);
        wr(4'h8, 8'h00);
        wr(4'h1, 8'h50);
        wr(4'h6, 8'h04);
        // Both run windows span 22 clock edges
        repeat (18) @(posedge core_clk);
        wr(4'h1, 8'h00);
        wr(4'h6, 8'h00);
        rd(4'h2, 8'(22 / DIV));
        rd(4'h3, 8'(22 / DIV));
        rd(4'h7, 8'(22 / DIV));
        rd(4'h4, 8'h81);
        // Timer 1 overflow while timer 0 split: tick but no flag
        wr(4'h0, 8'h63);
        wr(4'h4, 8'hff);
        wr(4'h5, 8'h40);
        wr(4'h1, 8'h40);
        pulse(2'd1, 4'd1);
        rd(4'h4, 8'h40);
        rd(4'h1, 8'h40);
        chk_ticks(2, 0);
        wr(4'h1, 8'h00);
        // Timer 2 capture
        wr(4'h7, 8'h10);
        wr(4'h8, 8'h00);
        wr(4'h6, 8'h0f);
        pulse(2'd2, 4'd2);
        pulse(2'd3, 4'd1);
        rd(4'h9, 8'h12);
        rd(4'ha, 8'h00);
        rd(4'h6, 8'h4f);
        rd(4'h7, 8'h12);
        // Timer 2 auto-reload
        wr(4'h6, 8'h00);
        wr(4'h7, 8'hfe);
        wr(4'h8, 8'hff);
        wr(4'h9, 8'h12);
        wr(4'ha, 8'h34);
        wr(4'h6, 8'h0e);
        pulse(2'd2, 4'd3);
        rd(4'h7, 8'h13);
        rd(4'h8, 8'h34);
        rd(4'h6, 8'h8e);
        pulse(2'd3, 4'd1);
        rd(4'h7, 8'h12);
        rd(4'h6, 8'hce);
        wr(4'h6, 8'h00);
        rd(4'h6, 8'h00);
        // Timer 2 baud mode
        wr(4'h7, 8'hff);
        wr(4'h8, 8'hff);
        wr(4'h9, 8'haa);
        wr(4'ha, 8'h55);
        wr(4'h6, 8'h17);
        pulse(2'd2, 4'd1);
        rd(4'h7, 8'haa);
        rd(4'h8, 8'h55);
        rd(4'h6, 8'h17);
        repeat (3) @(posedge core_clk);
        chk_ticks(2, 1);
        wrap_up();
    end
endmodule : tb_top
